// ### src/adw_consts.svh
// Constants for the anemometer diagnostic word block.
`ifndef ADW_CONSTS_SVH
`define ADW_CONSTS_SVH

// ============================================================
// Diagnostic word bit positions
`define ADW_BIT_AMP_LOW     4'h0
`define ADW_BIT_AMP_HIGH    4'h1
`define ADW_BIT_TRACKING    4'h2
`define ADW_BIT_DELTA_C     4'h3
`define ADW_BIT_ACQUIRING   4'h4
`define ADW_BIT_LOW_VOLT    4'h5
`define ADW_BIT_TRIGGER     4'h6
`define ADW_BIT_HUMIDITY    4'h7
`define ADW_BIT_MEMORY      4'h8
`define ADW_DIAG_RESET      32'h0000_0000

// ============================================================
// Result word layout: three wind components, temperature, diagnostic word
`define ADW_IDX_UX          3'h0
`define ADW_IDX_UY          3'h1
`define ADW_IDX_UZ          3'h2
`define ADW_IDX_TS          3'h3
`define ADW_IDX_DIAG        3'h4
`define ADW_RESULT_WORDS    3'h5
`define ADW_NOT_A_NUMBER    32'h7FC0_0000

// ============================================================
// Thresholds
`define ADW_AMP_LO_LIMIT    12'h100
`define ADW_AMP_HI_LIMIT    12'hF00
`define ADW_DELTA_C_MMPS    16'h0938
`define ADW_HUMIDITY_PCT    8'h50
`define ADW_JITTER_DIV      40'h0000_0000_14

// ============================================================
// Timing
`define ADW_CLK_HZ          40000000
`define ADW_TRIG_TIMEOUT_MS 1000
`define ADW_TRIG_TIMEOUT_CYC ((`ADW_CLK_HZ / 1000) * `ADW_TRIG_TIMEOUT_MS)

`endif

// ### src/adw_pkg.sv
// Types shared by the anemometer diagnostic word block.
package adw_pkg;

	// ============================================================
	// Front-end condition inputs sampled for each measurement.
	typedef struct packed {
		logic [11:0] amplitude;
		logic        trackPoor;
		logic [15:0] sosPathA;
		logic [15:0] sosPathB;
		logic [15:0] sosPathC;
		logic        lowVolt;
		logic [7:0]  humidity;
		logic        signatureBad;
	} adw_sense_t;

	// Science data of one measurement.
	typedef struct packed {
		logic [31:0] windX;
		logic [31:0] windY;
		logic [31:0] windZ;
		logic [31:0] sonicTemp;
	} adw_science_t;

	// ============================================================
	// Measurement sequencer states.
	typedef enum logic [1:0] {
		ADW_IDLE,
		ADW_MEASURE,
		ADW_STORE
	} adw_state_t;

endpackage : adw_pkg

// ### src/adw_result_mem.sv
// Small result memory holding the five words of the latest measurement.
`timescale 1ns/1ps

module adw_result_mem (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        wrEn,
	input  wire logic [2:0]  wrAddr,
	input  wire logic [31:0] wrData,
	input  wire logic        rdEn,
	input  wire logic [2:0]  rdAddr,
	output logic      [31:0] rdData
);

	logic [31:0] words [0:7];

	// ============================================================
	// Storage; contents are reset so an early read returns zero, not garbage.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				words[i] <= 32'h0000_0000;
			end
		end else if (wrEn) begin
			words[wrAddr] <= wrData;
		end
	end

	// Registered read port; unused slots above the result read as zero.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= 32'h0000_0000;
		end else if (rdEn) begin
			rdData <= words[rdAddr];
		end
	end

endmodule : adw_result_mem

// ### src/adw_diag_word.sv
// Measurement sequencer and diagnostic status word builder of the anemometer.
`timescale 1ns/1ps
`include "adw_consts.svh"

// How it works
// - the diagnostic status is one 32-bit word, stored after wind and temperature.
// - every bit is an independent flag; several may be set together.
// - bit 0 set when signal amplitude is below the lower limit.
// - bit 1 set when signal amplitude is above the upper limit.
// - bit 2 set when tracking reports a poor signal lock.
// - bit 3 set when path speeds of sound differ by more than 2.360 m/s.
// - bit 4 set while the device is still acquiring the signal.
// - bit 5 set when the supply comparator reports below 9.0 V.
// - bit 6 set when no trigger arrived for one second or longer.
// - bit 6 also set when trigger intervals vary by more than five percent.
// - bit 7 set when enclosure humidity exceeds 80 percent.
// - bit 8 set when a memory signature check fails.
// - while acquiring, wind and temperature read not-a-number and the flag shows it.
// - on the packet bus, triggering is carried by the protocol itself.
module adw_diag_word
	import adw_pkg::*;
#(
	parameter int unsigned TRIG_TIMEOUT_CYC = `ADW_TRIG_TIMEOUT_CYC
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         groupTrigPin,
	input  wire logic         packetTrig,
	input  wire logic         acquireCmd,
	input  wire logic         signalLocked,
	input  wire adw_sense_t   sense,
	input  wire adw_science_t science,
	input  wire logic         measDone,
	input  wire logic         readEn,
	input  wire logic [2:0]   readAddr,
	output logic              measStart,
	output logic              resultReady,
	output logic              readValid,
	output logic      [31:0]  readData,
	output logic      [31:0]  diagnosticStatusWord,
	output logic              acquiring
);

	// ============================================================
	// Trigger pin synchroniser: three stages, a change counts once stages two and three agree.
	logic trigSync1;
	logic trigSync2;
	logic trigSync3;
	logic trigLevel;
	logic pinRise;
	logic trigger;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trigSync1 <= 1'b0;
			trigSync2 <= 1'b0;
			trigSync3 <= 1'b0;
		end else begin
			trigSync1 <= groupTrigPin;
			trigSync2 <= trigSync1;
			trigSync3 <= trigSync2;
		end
	end

	// Accepted pin level; only agreeing stages move it, which rejects one-cycle glitches.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trigLevel <= 1'b0;
		end else if (trigSync2 == trigSync3) begin
			trigLevel <= trigSync3;
		end
	end

	// A group trigger from the serial bus pin or a packet-bus trigger both start a measurement.
	assign pinRise = (trigSync2 == trigSync3) && trigSync3 && !trigLevel;
	assign trigger = pinRise || packetTrig;

	// ============================================================
	// Trigger timing supervision.
	logic [31:0] intervalCount;
	logic [31:0] lastInterval;
	logic        haveInterval;
	logic        firstSeen;
	logic        jitterFlag;
	logic        timeoutFlag;
	logic [39:0] intervalDiff;
	logic [39:0] diffScaled;

	// Counts cycles since the last trigger and saturates so a long gap never wraps.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			intervalCount <= 32'h0000_0000;
		end else if (trigger) begin
			intervalCount <= 32'h0000_0001;
		end else if (intervalCount != 32'hFFFF_FFFF) begin
			intervalCount <= intervalCount + 32'h0000_0001;
		end
	end

	// Set once the gap reaches the timeout and re-judged at every trigger.
	// A result is stored just after its trigger, so the long gap must survive that trigger to be reported.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timeoutFlag <= 1'b0;
		end else if (trigger) begin
			timeoutFlag <= (intervalCount >= TRIG_TIMEOUT_CYC);
		end else if (intervalCount >= (TRIG_TIMEOUT_CYC - 32'd1)) begin
			timeoutFlag <= 1'b1;
		end
	end

	// Five percent check: |now - previous| * 20 > previous, done without a divider.
	always_comb begin
		if (intervalCount >= lastInterval) begin
			intervalDiff = {8'h00, intervalCount - lastInterval};
		end else begin
			intervalDiff = {8'h00, lastInterval - intervalCount};
		end
		diffScaled = 40'(intervalDiff * `ADW_JITTER_DIV);
	end

	// Interval history; the gap from reset to the first trigger is no trigger interval, so it is not compared.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lastInterval <= 32'h0000_0000;
			haveInterval <= 1'b0;
			jitterFlag   <= 1'b0;
			firstSeen    <= 1'b0;
		end else if (trigger) begin
			lastInterval <= intervalCount;
			firstSeen    <= 1'b1;
			haveInterval <= firstSeen;
			jitterFlag   <= haveInterval && (diffScaled > {8'h00, lastInterval});
		end
	end

	// ============================================================
	// Acquisition state: set by the acquire command, cleared once the front end locks.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acquiring <= 1'b1;
		end else if (acquireCmd) begin
			acquiring <= 1'b1;
		end else if (signalLocked) begin
			acquiring <= 1'b0;
		end
	end

	// ============================================================
	// Flag evaluation from the present conditions.
	logic [15:0] sosMax;
	logic [15:0] sosMin;
	logic [31:0] next_diag;

	always_comb begin
		sosMax = sense.sosPathA;
		sosMin = sense.sosPathA;
		if (sense.sosPathB > sosMax) sosMax = sense.sosPathB;
		if (sense.sosPathC > sosMax) sosMax = sense.sosPathC;
		if (sense.sosPathB < sosMin) sosMin = sense.sosPathB;
		if (sense.sosPathC < sosMin) sosMin = sense.sosPathC;
		// Independent flags; unused upper bits stay zero.
		next_diag = `ADW_DIAG_RESET;
		next_diag[`ADW_BIT_AMP_LOW]   = sense.amplitude < `ADW_AMP_LO_LIMIT;
		next_diag[`ADW_BIT_AMP_HIGH]  = sense.amplitude > `ADW_AMP_HI_LIMIT;
		next_diag[`ADW_BIT_TRACKING]  = sense.trackPoor;
		next_diag[`ADW_BIT_DELTA_C]   = 16'(sosMax - sosMin) > `ADW_DELTA_C_MMPS;
		next_diag[`ADW_BIT_ACQUIRING] = acquiring;
		next_diag[`ADW_BIT_LOW_VOLT]  = sense.lowVolt;
		next_diag[`ADW_BIT_TRIGGER]   = timeoutFlag || jitterFlag;
		next_diag[`ADW_BIT_HUMIDITY]  = sense.humidity > `ADW_HUMIDITY_PCT;
		next_diag[`ADW_BIT_MEMORY]    = sense.signatureBad;
	end

	// ============================================================
	// Measurement sequencer: trigger, wait for the front end, store five words.
	adw_state_t  state;
	logic [2:0]  storeIdx;
	logic        wrEn;
	logic [31:0] wrData;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= ADW_IDLE;
			storeIdx <= 3'h0;
		end else begin
			case (state)
				ADW_IDLE: begin
					if (trigger) begin
						state <= ADW_MEASURE;
					end
				end
				ADW_MEASURE: begin
					if (measDone) begin
						state    <= ADW_STORE;
						storeIdx <= `ADW_IDX_UX;
					end
				end
				ADW_STORE: begin
					if (storeIdx == `ADW_IDX_DIAG) begin
						state <= ADW_IDLE;
					end
					storeIdx <= storeIdx + 3'h1;
				end
				default: begin
					state <= ADW_IDLE;
				end
			endcase
		end
	end

	// Start strobe to the front end; a trigger during a measurement is dropped.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			measStart <= 1'b0;
		end else begin
			measStart <= (state == ADW_IDLE) && trigger;
		end
	end

	// Word to store; science words become not-a-number while acquiring.
	always_comb begin
		wrEn = (state == ADW_STORE);
		case (storeIdx)
			`ADW_IDX_UX:   wrData = acquiring ? `ADW_NOT_A_NUMBER : science.windX;
			`ADW_IDX_UY:   wrData = acquiring ? `ADW_NOT_A_NUMBER : science.windY;
			`ADW_IDX_UZ:   wrData = acquiring ? `ADW_NOT_A_NUMBER : science.windZ;
			`ADW_IDX_TS:   wrData = acquiring ? `ADW_NOT_A_NUMBER : science.sonicTemp;
			`ADW_IDX_DIAG: wrData = next_diag;
			default:       wrData = 32'h0000_0000;
		endcase
	end

	// Latest status word, rebuilt at every measurement so cleared causes drop out.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			diagnosticStatusWord <= `ADW_DIAG_RESET;
		end else if (wrEn && storeIdx == `ADW_IDX_DIAG) begin
			diagnosticStatusWord <= next_diag;
		end
	end

	// Result ready pulse after the last word is written.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			resultReady <= 1'b0;
		end else begin
			resultReady <= wrEn && (storeIdx == `ADW_IDX_DIAG);
		end
	end

	// ============================================================
	// Result store and readout.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			readValid <= 1'b0;
		end else begin
			readValid <= readEn;
		end
	end

	adw_result_mem resultMem (
		.core_clk (core_clk),
		.rstn     (rstn),
		.wrEn     (wrEn),
		.wrAddr   (storeIdx),
		.wrData   (wrData),
		.rdEn     (readEn),
		.rdAddr   (readAddr),
		.rdData   (readData)
	);

endmodule : adw_diag_word

// ### dv/adw_logger_model.sv
// Behavioural data logger that paces triggers and reads result words back.
`timescale 1ns/1ps

module adw_logger_model (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        readValid,
	input  wire logic [31:0] readData,
	output logic             groupTrigPin,
	output logic             packetTrig,
	output logic             readEn,
	output logic [2:0]       readAddr
);
	// ============================================================
	// Trigger pacing
	int cyc = 0;
	int lastTrig = 0;

	// Idle levels at time zero.
	initial begin
		groupTrigPin = 1'b0;
		packetTrig = 1'b0;
		readEn = 1'b0;
		readAddr = 3'h0;
	end

	// Free-running cycle count; the logger always triggers, never self-trigger mode.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	// Pacing by cycle count keeps intervals exact, so jitter appears only where a test asks.
	task automatic fire(input int gap, input bit usePin);
		while (cyc - lastTrig < gap) @(negedge core_clk);
		lastTrig = cyc;
		if (usePin) groupTrigPin = 1'b1;
		else packetTrig = 1'b1;
		@(negedge core_clk);
		packetTrig = 1'b0;
		if (usePin) repeat (5) @(negedge core_clk);
		groupTrigPin = 1'b0;
	endtask : fire

	// One strobe per word; a missing valid returns corrupted data so it cannot pass.
	task automatic readWord(input logic [2:0] addr, output logic [31:0] data);
		readEn = 1'b1;
		readAddr = addr;
		@(negedge core_clk);
		readEn = 1'b0;
		data = readValid ? readData : ~readData;
		@(negedge core_clk);
	endtask : readWord
endmodule : adw_logger_model

// ### dv/adw_diag_monitor.sv
// Port checker of the diagnostic word block, bound to its top module.
`timescale 1ns/1ps
`include "adw_consts.svh"

module adw_diag_monitor
	import adw_pkg::*;
#(
	parameter int unsigned TRIG_TIMEOUT_CYC = 200
) (
	input wire logic         core_clk,
	input wire logic         rstn,
	input wire logic         groupTrigPin,
	input wire logic         packetTrig,
	input wire logic         acquireCmd,
	input wire logic         signalLocked,
	input wire adw_sense_t   sense,
	input wire adw_science_t science,
	input wire logic         measDone,
	input wire logic         readEn,
	input wire logic [2:0]   readAddr,
	input wire logic         measStart,
	input wire logic         resultReady,
	input wire logic         readValid,
	input wire logic [31:0]  readData,
	input wire logic [31:0]  diagnosticStatusWord,
	input wire logic         acquiring
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// ============================================================
	// Helper state
	logic busy;
	logic measuring;

	// Triggers during a measurement are refused, so the start check must know when idle.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) busy <= 1'b0;
		else if (measStart) busy <= 1'b1;
		else if (resultReady) busy <= 1'b0;
	end

	// Front end is measuring from the start pulse until done is taken.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) measuring <= 1'b0;
		else if (measStart) measuring <= 1'b1;
		else if (measDone) measuring <= 1'b0;
	end

	// ============================================================
	// Assertions
	sequence storeTaken;
		measDone && measuring;
	endsequence
	sequence resultOut;
		##6 resultReady;
	endsequence

	start_on_trig_a: assert property (packetTrig && !busy && !measStart |=> measStart)
		else $error("trigger in idle gave no start pulse");
	result_after_done_a: assert property (storeTaken |-> resultOut)
		else $error("result pulse not six cycles after done");
	diag_read_a: assert property (readEn && readAddr == `ADW_IDX_DIAG |=> readValid && readData == diagnosticStatusWord)
		else $error("diag word read differs from status port");
	upper_zero_a: assert property (diagnosticStatusWord[31:9] == 23'h0)
		else $error("undefined status bits not zero");
	acq_set_a: assert property (acquireCmd |=> acquiring)
		else $error("acquire command did not set acquiring");
	amp_low_a: assert property (resultReady |-> diagnosticStatusWord[0] == (sense.amplitude < `ADW_AMP_LO_LIMIT))
		else $error("low amplitude flag wrong");
	amp_high_a: assert property (resultReady |-> diagnosticStatusWord[1] == (sense.amplitude > `ADW_AMP_HI_LIMIT))
		else $error("high amplitude flag wrong");
	humid_flag_a: assert property (resultReady |-> diagnosticStatusWord[7] == (sense.humidity > `ADW_HUMIDITY_PCT))
		else $error("humidity flag wrong");
	flag_copy_a: assert property (resultReady |->
		{diagnosticStatusWord[8], diagnosticStatusWord[5], diagnosticStatusWord[2]} ==
		{sense.signatureBad, sense.lowVolt, sense.trackPoor})
		else $error("memory, voltage or tracking flag wrong");
endmodule : adw_diag_monitor

bind adw_diag_word adw_diag_monitor #(.TRIG_TIMEOUT_CYC(TRIG_TIMEOUT_CYC)) mon (
	.core_clk(core_clk), .rstn(rstn), .groupTrigPin(groupTrigPin), .packetTrig(packetTrig),
	.acquireCmd(acquireCmd), .signalLocked(signalLocked), .sense(sense), .science(science),
	.measDone(measDone), .readEn(readEn), .readAddr(readAddr), .measStart(measStart),
	.resultReady(resultReady), .readValid(readValid), .readData(readData),
	.diagnosticStatusWord(diagnosticStatusWord), .acquiring(acquiring));

// ### dv/testbench.sv
// Self-checking testbench of the anemometer diagnostic word block.
`timescale 1ns/1ps
`include "adw_consts.svh"

module testbench
	import adw_pkg::*;
;
	// ============================================================
	// Signals and tables
	logic         core_clk;
	logic         rstn;
	logic         groupTrigPin;
	logic         packetTrig;
	logic         acquireCmd;
	logic         signalLocked;
	logic         measDone;
	logic         readEn;
	logic [2:0]   readAddr;
	adw_sense_t   sense;
	adw_sense_t   base;
	adw_science_t science;
	logic         measStart;
	logic         resultReady;
	logic         readValid;
	logic [31:0]  readData;
	logic [31:0]  diagWord;
	logic         acquiring;
	int           badCount = 0;
	int           starts = 0;
	int           compares = 0;
	int           cycles = 0;
	int           k;
	int           gaps [11] = '{62, 78, 78, 60, 250, 250, 199, 200, 199, 60, 60};
	bit           jit [11] = '{0, 1, 0, 1, 1, 1, 1, 1, 0, 1, 0};
	logic [31:0]  expFlag [12] = '{32'h1, 32'h0, 32'h2, 32'h0, 32'h4, 32'h0, 32'h8, 32'h20, 32'h0, 32'h80,
		32'h100, 32'h1AD};

	adw_diag_word #(.TRIG_TIMEOUT_CYC(200)) dut (
		.core_clk(core_clk), .rstn(rstn), .groupTrigPin(groupTrigPin), .packetTrig(packetTrig),
		.acquireCmd(acquireCmd), .signalLocked(signalLocked), .sense(sense), .science(science),
		.measDone(measDone), .readEn(readEn), .readAddr(readAddr), .measStart(measStart),
		.resultReady(resultReady), .readValid(readValid), .readData(readData),
		.diagnosticStatusWord(diagWord), .acquiring(acquiring));
	adw_logger_model lg (
		.core_clk(core_clk), .rstn(rstn), .readValid(readValid), .readData(readData),
		.groupTrigPin(groupTrigPin), .packetTrig(packetTrig), .readEn(readEn), .readAddr(readAddr));

	// ============================================================
	// Clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// About thirty measurements need some three thousand cycles; the ceiling leaves wide margin.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			endSim();
		end
	end

	// Start pulses are counted as sampled, so a pulse that ends before a task looks is not missed.
	always @(posedge core_clk) begin
		if (measStart) begin
			starts <= starts + 1;
		end
	end

	// ============================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Case 11 combines several conditions to show the flags add up.
	task automatic setSense(input int n);
		sense = base;
		case (n)
			0, 11: sense.amplitude = 12'h0FF;
			1: sense.amplitude = 12'h100;
			2: sense.amplitude = 12'hF01;
			3: sense.amplitude = 12'hF00;
			5: sense.sosPathB = 16'h3938;
			6: sense.sosPathB = 16'h3939;
			8: sense.humidity = 8'h50;
			default: ;
		endcase
		sense.trackPoor = (n == 4 || n == 11);
		sense.lowVolt = (n == 7 || n == 11);
		sense.signatureBad = (n == 10 || n == 11);
		if (n == 9 || n == 11) sense.humidity = 8'h51;
		if (n == 11) sense.sosPathC = 16'h3939;
	endtask : setSense

	// One triggered measurement, then all five result words read back.
	task automatic measure(input int gap, input bit pin, input logic [31:0] expDiag, input bit acq,
		input logic [31:0] care);
		logic [31:0] w;
		int i;
		int s0;
		s0 = starts;
		lg.fire(gap, pin);
		for (i = 0; i < 12 && starts == s0; i++) @(negedge core_clk);
		check("start pulses", 32'(starts - s0), 32'h1);
		repeat (2) @(negedge core_clk);
		measDone = 1'b1;
		@(negedge core_clk);
		measDone = 1'b0;
		for (i = 0; i < 12 && !resultReady; i++) @(negedge core_clk);
		check("result ready", {31'h0, resultReady}, 32'h1);
		@(negedge core_clk);
		for (i = 0; i < 4; i++) begin
			lg.readWord(i[2:0], w);
			check("science", w, acq ? `ADW_NOT_A_NUMBER : science[127 - 32 * i -: 32]);
		end
		lg.readWord(3'h4, w);
		check("diag", w & care, expDiag & care);
		check("diag port", diagWord & care, expDiag & care);
	endtask : measure

	// Prints the counts and the verdict, then stops.
	task automatic endSim;
		$display("comparisons %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : endSim

	// ============================================================
	// Main sequence; early bit 6 is masked until two steady intervals exist.
	initial begin
		base = '0;
		base.amplitude = 12'h800;
		base.sosPathA = 16'h3000;
		base.sosPathB = 16'h3000;
		base.sosPathC = 16'h3000;
		base.humidity = 8'h20;
		sense = base;
		science = {32'h3F80_0000, 32'hBF80_0000, 32'h4000_0000, 32'h41A0_0000};
		rstn = 1'b0;
		acquireCmd = 1'b0;
		signalLocked = 1'b0;
		measDone = 1'b0;
		repeat (4) @(negedge core_clk);
		rstn = 1'b1;
		check("acquiring", {31'h0, acquiring}, 32'h1);
		check("diag reset", diagWord, `ADW_DIAG_RESET);
		measure(60, 1'b1, 32'h10, 1'b1, ~32'h40);
		signalLocked = 1'b1;
		measure(60, 1'b0, 32'h0, 1'b0, ~32'h40);
		measure(60, 1'b0, 32'h0, 1'b0, ~32'h40);
		for (k = 0; k < 12; k++) begin
			setSense(k);
			measure(60, 1'b0, expFlag[k], 1'b0, ~32'h0);
		end
		sense = base;
		for (k = 0; k < 11; k++) begin
			measure(gaps[k], 1'b0, jit[k] ? 32'h40 : 32'h0, 1'b0, ~32'h0);
		end
		signalLocked = 1'b0;
		acquireCmd = 1'b1;
		@(negedge core_clk);
		acquireCmd = 1'b0;
		measure(60, 1'b0, 32'h10, 1'b1, ~32'h0);
		signalLocked = 1'b1;
		measure(60, 1'b0, 32'h0, 1'b0, ~32'h0);
		endSim();
	end
endmodule : testbench
